// ===== hdl/ctsu_act_mon.sv
`timescale 1ns/1ps
`default_nettype none
module ctsu_act_mon #(
  parameter int P_TIMEOUT = 500_000_000
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_enable,
  input wire logic i_activity,
  output logic o_fail
);
  localparam int W = $clog2(P_TIMEOUT + 1);
  if (P_TIMEOUT < 2) begin : g_chk
    $error("Timeout too short");
  end
  logic [W-1:0] cnt_reg, cnt_next;
  logic fail_reg, fail_next;

  always_comb begin
    cnt_next = cnt_reg;
    fail_next = fail_reg;
    if (!i_enable || i_activity) begin
      cnt_next = '0;
      fail_next = 1'b0;
    end else if (cnt_reg == W'(P_TIMEOUT - 1)) begin
      fail_next = 1'b1;
    end else begin
      cnt_next = cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      cnt_reg <= '0;
      fail_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      fail_reg <= fail_next;
    end
  end
  assign o_fail = fail_reg;
endmodule
`default_nettype wire

// ===== hdl/ctsu_pkg.sv
package ctsu_pkg;
  // Overview of operation
  // - A signed seconds adjustment in tenths is added to the running time; the setting resets to zero.
  // - A whole-hour shift from -24 to +24 is added to the running time; the setting resets to zero.
  // - Hours are shown in twelve-hour or twenty-four-hour form as the clock mode selects.
  // - The time base follows one source: internal, 50 Hz mains, 60 Hz mains or satellite receiver.
  // - A lost synchronisation input raises the sync failure message on the display.
  // - The satellite serial receiver runs at a selectable baud rate, 4800 after reset.
  // - Seven display formats exist; the six-digit ones are refused on a four-digit display.
  // - Adjustments are reachable from function entry with quick access on, else only from calibration entry.
  // - Received universal time is shifted by -12 to +13 hours in half-hour steps, or left as local.
  // - The year is settable up to 2099 and drives the year fields.
  // - The month is settable from January to December.
  // - Four alarm relay outputs are standard and four more are optional.
  // - The time of day is settable as seconds since midnight, 0 to 86399.
  localparam int CLK_HZ = 250_000_000;
  localparam int TENTHS_PER_SEC = 10;
  localparam int CYC_PER_TENTH = CLK_HZ / TENTHS_PER_SEC;
  localparam int SYNC_TIMEOUT_MS = 2000;
  localparam int SYNC_TIMEOUT_CYC = (CLK_HZ / 1000) * SYNC_TIMEOUT_MS;
  localparam logic [2:0] MAINS50_PER_TENTH = 3'h5;
  localparam logic [2:0] MAINS60_PER_TENTH = 3'h6;
  localparam logic [19:0] DAY_TENTHS = 20'hd2f00;
  localparam logic [16:0] DAY_SECS_MAX = 17'h1517f;
  localparam int SECS_PER_HOUR = 3600;
  localparam int SECS_PER_MIN = 60;
  localparam logic [4:0] HOURS_PER_DAY = 5'h18;
  localparam logic [4:0] HOURS_HALF = 5'h0c;
  localparam logic [5:0] MINS_PER_HOUR = 6'h3c;
  localparam logic signed [22:0] TENTHS_SEC_S = 23'sha;
  localparam logic signed [22:0] TENTHS_PER_HOUR = 23'sh8ca0;
  localparam logic signed [22:0] TENTHS_PER_HALF = 23'sh4650;
  localparam logic signed [5:0] ADJ_HOUR_MAX = 6'sh18;
  localparam logic signed [5:0] UTC_MIN = -6'sh18;
  localparam logic signed [5:0] UTC_MAX = 6'sh1a;
  localparam logic signed [5:0] UTC_RST = 6'sh14;
  localparam int UTC_LOCAL_BIT = 6;
  localparam logic [11:0] YEAR_MIN = 12'h7da;
  localparam logic [11:0] YEAR_MAX = 12'h833;
  localparam logic [3:0] MONTH_MAX = 4'hc;
  localparam logic [3:0] MONTH_RST = 4'h1;
  localparam logic [2:0] BAUD_RST = 3'h2;
  localparam int SAT_MARK_BIT = 7;
  localparam logic [7:0] A_CTRL = 8'h00, A_BAUD = 8'h04, A_ADJ_SEC = 8'h08, A_ADJ_HOUR = 8'h0c;
  localparam logic [7:0] A_UTC = 8'h10, A_YEAR = 8'h14, A_MONTH = 8'h18, A_TIME = 8'h1c;
  localparam logic [7:0] A_STATUS = 8'h20, A_MASK = 8'h24, A_RELAY = 8'h28, A_DAYS = 8'h2c;
  localparam int ST_FAIL = 0, ST_FRAME = 1, ST_DAY = 2, ST_W = 3;

  typedef enum logic [1:0] {SRC_INT, SRC_50, SRC_60, SRC_SAT} ctsu_src_t;
  typedef enum logic [1:0] {ENT_NONE, ENT_FUNCTION_ENTRY_MODE, ENT_CAL} ctsu_entry_t;
  typedef enum logic [2:0] {FMT_HMS, FMT_HM, FMT_DDD, FMT_DM, FMT_MD, FMT_DMY, FMT_MDY} ctsu_fmt_t;
  typedef struct packed {
    ctsu_fmt_t fmt;
    ctsu_entry_t entry;
    ctsu_src_t src;
    logic quick;
    logic twelve;
  } ctsu_ctrl_t;
  typedef struct packed {
    logic [4:0] hours;
    logic [5:0] minutes;
    logic [5:0] seconds;
    logic pm;
    ctsu_fmt_t fmt;
  } ctsu_disp_t;
  localparam ctsu_ctrl_t CTRL_RST = '{fmt: FMT_HM, entry: ENT_NONE, src: SRC_INT, quick: 1'b1, twelve: 1'b0};

  function automatic int baud_div(input logic [2:0] code);
    case (code)
      3'h0: return CLK_HZ / 1200;
      3'h1: return CLK_HZ / 2400;
      3'h2: return CLK_HZ / 4800;
      3'h3: return CLK_HZ / 9600;
      3'h4: return CLK_HZ / 19200;
      3'h5: return CLK_HZ / 38400;
      3'h6: return CLK_HZ / 57600;
      default: return CLK_HZ / 115200;
    endcase
  endfunction
endpackage

// ===== hdl/ctsu_top.sv
`timescale 1ns/1ps
`default_nettype none
module ctsu_top
  import ctsu_pkg::*;
#(
  parameter int P_CYC_PER_TENTH = CYC_PER_TENTH,
  parameter int P_SYNC_TIMEOUT = SYNC_TIMEOUT_CYC,
  parameter int P_DIGITS = 6,
  parameter int P_RELAYS = 4,
  parameter bit P_AC_SUPPLY = 1'b1
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic i_mains,
  input wire logic i_sat_rx,
  output ctsu_disp_t o_disp,
  output logic [15:0] o_day_count,
  output logic [11:0] o_year,
  output logic [3:0] o_month,
  output logic o_sync_fail_msg,
  output logic [7:0] o_relay,
  output logic o_irq
);
  if (P_CYC_PER_TENTH < 2 || (P_DIGITS != 4 && P_DIGITS != 6) || P_RELAYS < 4 || P_RELAYS > 8) begin : g_chk
    $error("Unsupported parameter value");
  end

  localparam int TW = $clog2(P_CYC_PER_TENTH);

  logic mains_s1_reg, mains_s2_reg, mains_s3_reg, sat_s1_reg, sat_s2_reg;
  ctsu_ctrl_t ctrl_reg, ctrl_next;
  logic [2:0] baud_reg, baud_next;
  logic [15:0] adj_sec_reg, adj_sec_next;
  logic signed [5:0] adj_hr_reg, adj_hr_next;
  logic signed [5:0] utc_reg, utc_next;
  logic utc_local_reg, utc_local_next;
  logic [11:0] year_reg, year_next;
  logic [3:0] month_reg, month_next;
  logic [19:0] time_reg, time_next;
  logic [15:0] day_reg, day_next;
  logic [ST_W-1:0] st_reg, st_next, mask_reg, mask_next, ev;
  logic [7:0] relay_reg, relay_next, relay_mask;
  logic [TW-1:0] tcnt_reg, tcnt_next;
  logic [2:0] mcnt_reg, mcnt_next, mains_per;
  logic [1:0] fidx_reg, fidx_next;
  logic [4:0] fhour_reg, fhour_next;
  logic [5:0] fmin_reg, fmin_next;
  logic [31:0] rdata_reg, rdata_next;
  ctsu_disp_t disp_reg, disp_next;
  logic fail_msg_reg, irq_reg, irq_next;

  logic [7:0] rx_data;
  logic rx_valid, mon_fail;
  logic [17:0] baud_div_q;
  logic is_mains, mains_edge, int_tick, mains_tick, tick, adj_ok, frame_ok, day_roll;
  logic [16:0] secs, sat_secs;
  logic [4:0] hrs;
  logic signed [22:0] delta, sum, sat_val;
  ctsu_ctrl_t cw;

  function automatic logic [19:0] wrap_day(input logic signed [22:0] v);
    logic signed [22:0] d;
    d = signed'({3'h0, DAY_TENTHS});
    if (v < 0) return 20'(v + d);
    // A tick on top of a full day of shift can pass two day lengths
    else if (v >= d + d) return 20'(v - d - d);
    else if (v >= d) return 20'(v - d);
    else return 20'(v);
  endfunction

  function automatic logic fmt_ok(input ctsu_fmt_t f);
    case (f)
      FMT_HM, FMT_DDD, FMT_DM, FMT_MD: return 1'b1;
      FMT_HMS, FMT_DMY, FMT_MDY: return P_DIGITS >= 6;
      default: return 1'b0;
    endcase
  endfunction

  // Pins are asynchronous to i_clk: two flops before any logic looks at them
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      mains_s1_reg <= 1'b0;
      mains_s2_reg <= 1'b0;
      mains_s3_reg <= 1'b0;
      sat_s1_reg <= 1'b1;
      sat_s2_reg <= 1'b1;
    end else begin
      mains_s1_reg <= i_mains;
      mains_s2_reg <= mains_s1_reg;
      mains_s3_reg <= mains_s2_reg;
      sat_s1_reg <= i_sat_rx;
      sat_s2_reg <= sat_s1_reg;
    end
  end

  assign baud_div_q = 18'(baud_div(baud_reg));

  ctsu_uart_rx #(.P_DIV_W(18)) u_rx (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_rx(sat_s2_reg),
    .i_div(baud_div_q),
    .o_data(rx_data),
    .o_valid(rx_valid)
  );

  // One watchdog serves whichever source is picked; internal never fails
  ctsu_act_mon #(.P_TIMEOUT(P_SYNC_TIMEOUT)) u_mon (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_enable(ctrl_reg.src != SRC_INT),
    .i_activity(is_mains ? mains_edge : frame_ok),
    .o_fail(mon_fail)
  );

  for (genvar g = 0; g < 8; g++) begin : g_relay
    assign relay_mask[g] = (g < P_RELAYS);
  end

  assign is_mains = (ctrl_reg.src == SRC_50) || (ctrl_reg.src == SRC_60);
  assign mains_edge = mains_s2_reg && !mains_s3_reg;
  assign mains_per = (ctrl_reg.src == SRC_60) ? MAINS60_PER_TENTH : MAINS50_PER_TENTH;
  assign int_tick = (tcnt_reg == TW'(P_CYC_PER_TENTH - 1));
  assign mains_tick = mains_edge && (mcnt_reg == mains_per - 3'h1);
  // A dead mains reference falls back to the crystal so the clock keeps running
  assign tick = (is_mains && !mon_fail) ? mains_tick : int_tick;
  assign adj_ok = (ctrl_reg.entry == ENT_CAL) || (ctrl_reg.entry == ENT_FUNCTION_ENTRY_MODE && ctrl_reg.quick);
  assign secs = 17'(time_reg / 20'(TENTHS_PER_SEC));
  assign hrs = 5'(secs / 17'(SECS_PER_HOUR));
  assign sat_secs = 17'(fhour_reg * 17'(SECS_PER_HOUR)) + 17'(fmin_reg * 17'(SECS_PER_MIN)) + 17'(rx_data);

  always_comb begin
    ctrl_next = ctrl_reg;
    baud_next = baud_reg;
    adj_sec_next = adj_sec_reg;
    adj_hr_next = adj_hr_reg;
    utc_next = utc_reg;
    utc_local_next = utc_local_reg;
    year_next = year_reg;
    month_next = month_reg;
    day_next = day_reg;
    mask_next = mask_reg;
    relay_next = relay_reg;
    fidx_next = fidx_reg;
    fhour_next = fhour_reg;
    fmin_next = fmin_reg;
    frame_ok = 1'b0;
    cw = ctsu_ctrl_t'(i_wdata[$bits(ctsu_ctrl_t)-1:0]);
    tcnt_next = int_tick ? '0 : tcnt_reg + 1'b1;
    mcnt_next = mcnt_reg;
    if (mains_edge) mcnt_next = mains_tick ? 3'h0 : mcnt_reg + 3'h1;

    // Satellite frame: hours byte carries the mark bit, then minutes, then seconds
    if (rx_valid && ctrl_reg.src == SRC_SAT) begin
      if (rx_data[SAT_MARK_BIT]) begin
        fhour_next = rx_data[4:0];
        fidx_next = 2'h1;
      end else if (fidx_reg == 2'h1) begin
        fmin_next = rx_data[5:0];
        fidx_next = 2'h2;
      end else if (fidx_reg == 2'h2) begin
        fidx_next = 2'h0;
        frame_ok = (fhour_reg < HOURS_PER_DAY) && (fmin_reg < MINS_PER_HOUR) && (rx_data < 8'(MINS_PER_HOUR));
      end
    end
    sat_val = signed'({6'h0, sat_secs}) * TENTHS_SEC_S;
    if (!utc_local_reg) sat_val = sat_val + 23'(utc_reg) * TENTHS_PER_HALF;

    delta = tick ? 23'sh1 : 23'sh0;
    if (i_wr && adj_ok && i_addr == A_ADJ_SEC) begin
      adj_sec_next = i_wdata[15:0];
      delta = delta + 23'(signed'(i_wdata[15:0]));
    end
    if (i_wr && adj_ok && i_addr == A_ADJ_HOUR && signed'(i_wdata[5:0]) >= -ADJ_HOUR_MAX
        && signed'(i_wdata[5:0]) <= ADJ_HOUR_MAX) begin
      adj_hr_next = signed'(i_wdata[5:0]);
      delta = delta + 23'(signed'(i_wdata[5:0])) * TENTHS_PER_HOUR;
    end
    sum = signed'({3'h0, time_reg}) + delta;
    day_roll = tick && (sum >= signed'({3'h0, DAY_TENTHS}));
    time_next = wrap_day(sum);
    if (frame_ok) time_next = wrap_day(sat_val);
    if (day_roll) day_next = day_reg + 16'h1;

    if (i_wr) begin
      case (i_addr)
        A_CTRL: begin
          if (!P_AC_SUPPLY && (cw.src == SRC_50 || cw.src == SRC_60)) cw.src = ctrl_reg.src;
          if (!fmt_ok(cw.fmt)) cw.fmt = ctrl_reg.fmt;
          if (cw.entry != ENT_NONE && cw.entry != ENT_FUNCTION_ENTRY_MODE && cw.entry != ENT_CAL) cw.entry = ctrl_reg.entry;
          ctrl_next = cw;
        end
        A_BAUD: baud_next = i_wdata[2:0];
        A_UTC: if (signed'(i_wdata[5:0]) >= UTC_MIN && signed'(i_wdata[5:0]) <= UTC_MAX) begin
          utc_next = signed'(i_wdata[5:0]);
          utc_local_next = i_wdata[UTC_LOCAL_BIT];
        end
        A_YEAR: if (i_wdata[11:0] >= YEAR_MIN && i_wdata[11:0] <= YEAR_MAX) year_next = i_wdata[11:0];
        A_MONTH: if (i_wdata[3:0] != 4'h0 && i_wdata[3:0] <= MONTH_MAX) month_next = i_wdata[3:0];
        A_TIME: if (i_wdata[16:0] <= DAY_SECS_MAX) begin
          time_next = 20'({3'h0, i_wdata[16:0]} * 20'(TENTHS_PER_SEC));
        end
        A_MASK: mask_next = i_wdata[ST_W-1:0];
        A_RELAY: relay_next = i_wdata[7:0] & relay_mask;
        A_DAYS: day_next = i_wdata[15:0];
        default: ;
      endcase
    end

    ev = '0;
    ev[ST_FAIL] = mon_fail && !fail_msg_reg;
    ev[ST_FRAME] = frame_ok;
    ev[ST_DAY] = day_roll;
    // A new event in the clearing cycle stays set
    st_next = (st_reg & ~((i_wr && i_addr == A_STATUS) ? i_wdata[ST_W-1:0] : '0)) | ev;
    irq_next = |(st_next & mask_next);

    rdata_next = 32'h0;
    if (i_rd) begin
      case (i_addr)
        A_CTRL: rdata_next = 32'(ctrl_reg);
        A_BAUD: rdata_next = 32'(baud_reg);
        A_ADJ_SEC: rdata_next = 32'(adj_sec_reg);
        A_ADJ_HOUR: rdata_next = 32'(unsigned'(adj_hr_reg));
        A_UTC: rdata_next = 32'({utc_local_reg, unsigned'(utc_reg)});
        A_YEAR: rdata_next = 32'(year_reg);
        A_MONTH: rdata_next = 32'(month_reg);
        A_TIME: rdata_next = 32'(secs);
        A_STATUS: rdata_next = 32'(st_reg);
        A_MASK: rdata_next = 32'(mask_reg);
        A_RELAY: rdata_next = 32'(relay_reg);
        A_DAYS: rdata_next = 32'(day_reg);
        default: rdata_next = 32'h0;
      endcase
    end

    disp_next.minutes = 6'((secs % 17'(SECS_PER_HOUR)) / 17'(SECS_PER_MIN));
    disp_next.seconds = 6'(secs % 17'(SECS_PER_MIN));
    disp_next.fmt = ctrl_reg.fmt;
    disp_next.pm = hrs >= HOURS_HALF;
    disp_next.hours = hrs;
    if (ctrl_reg.twelve) begin
      if (hrs == 5'h0) disp_next.hours = HOURS_HALF;
      else if (hrs > HOURS_HALF) disp_next.hours = hrs - HOURS_HALF;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      ctrl_reg <= CTRL_RST;
      baud_reg <= BAUD_RST;
      adj_sec_reg <= 16'h0;
      adj_hr_reg <= 6'sh0;
      utc_reg <= UTC_RST;
      utc_local_reg <= 1'b0;
      year_reg <= YEAR_MIN;
      month_reg <= MONTH_RST;
      time_reg <= 20'h0;
      day_reg <= 16'h0;
      st_reg <= '0;
      mask_reg <= '0;
      relay_reg <= 8'h0;
      tcnt_reg <= '0;
      mcnt_reg <= 3'h0;
      fidx_reg <= 2'h0;
      fhour_reg <= 5'h0;
      fmin_reg <= 6'h0;
      rdata_reg <= 32'h0;
      disp_reg <= '0;
      fail_msg_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      baud_reg <= baud_next;
      adj_sec_reg <= adj_sec_next;
      adj_hr_reg <= adj_hr_next;
      utc_reg <= utc_next;
      utc_local_reg <= utc_local_next;
      year_reg <= year_next;
      month_reg <= month_next;
      time_reg <= time_next;
      day_reg <= day_next;
      st_reg <= st_next;
      mask_reg <= mask_next;
      relay_reg <= relay_next;
      tcnt_reg <= tcnt_next;
      mcnt_reg <= mcnt_next;
      fidx_reg <= fidx_next;
      fhour_reg <= fhour_next;
      fmin_reg <= fmin_next;
      rdata_reg <= rdata_next;
      disp_reg <= disp_next;
      fail_msg_reg <= mon_fail;
      irq_reg <= irq_next;
    end
  end

  assign o_rdata = rdata_reg;
  assign o_disp = disp_reg;
  assign o_day_count = day_reg;
  assign o_year = year_reg;
  assign o_month = month_reg;
  assign o_sync_fail_msg = fail_msg_reg;
  assign o_relay = relay_reg;
  assign o_irq = irq_reg;

  default clocking dc @(posedge i_clk); endclocking
  default disable iff (i_reset);

  a_adj_sec_apply: assert property ((i_wr && adj_ok && i_addr == A_ADJ_SEC) |=>
    adj_sec_reg == $past(i_wdata[15:0])) else $error("Seconds adjust not stored");
  a_adj_hour_lim: assert property (adj_hr_reg >= -ADJ_HOUR_MAX && adj_hr_reg <= ADJ_HOUR_MAX)
    else $error("Hour shift out of range");
  a_twelve_hour: assert property ((ctrl_reg.twelve && $past(ctrl_reg.twelve)) |->
    (o_disp.hours >= 5'h1 && o_disp.hours <= HOURS_HALF)) else $error("Twelve hour value wrong");
  a_dc_no_mains: assert property (!P_AC_SUPPLY |-> !is_mains) else $error("Mains source on DC unit");
  a_fail_msg: assert property (mon_fail |=> o_sync_fail_msg ##1 (o_sync_fail_msg == $past(mon_fail)))
    else $error("Sync fail message not shown");
  a_baud_track: assert property ((i_wr && i_addr == A_BAUD) |=>
    baud_div_q == 18'(baud_div($past(i_wdata[2:0])))) else $error("Baud divider mismatch");
  a_fmt_digits: assert property ((P_DIGITS < 6) |-> fmt_ok(ctrl_reg.fmt)) else $error("Format too wide");
  a_adj_locked: assert property ((i_wr && !adj_ok && (i_addr == A_ADJ_SEC || i_addr == A_ADJ_HOUR)) |=>
    ($stable(adj_sec_reg) && $stable(adj_hr_reg))) else $error("Adjust reached while locked");
  a_utc_range: assert property (utc_reg >= UTC_MIN && utc_reg <= UTC_MAX) else $error("UTC offset range");
  a_year_max: assert property (o_year <= YEAR_MAX) else $error("Year above limit");
  a_month_rng: assert property (o_month != 4'h0 && o_month <= MONTH_MAX) else $error("Month invalid");
  a_relay_mask: assert property ((o_relay & ~relay_mask) == 8'h0) else $error("Absent relay driven");
  a_time_set: assert property ((i_wr && i_addr == A_TIME && i_wdata[16:0] <= DAY_SECS_MAX) |=>
    time_reg == 20'($past(i_wdata[16:0]) * 20'(TENTHS_PER_SEC))) else $error("Time set wrong");
  a_tick_adv: assert property ((tick && !i_wr && !frame_ok && time_reg < DAY_TENTHS - 20'h1) |=>
    time_reg == $past(time_reg) + 20'h1) else $error("Tenth tick lost");
  a_day_roll: assert property ((tick && !i_wr && !frame_ok && time_reg == DAY_TENTHS - 20'h1) |=>
    (time_reg == 20'h0 && o_day_count == $past(o_day_count) + 16'h1)) else $error("Day rollover lost");
  a_sync_recover: assert property (frame_ok |=> !mon_fail) else $error("Frame left sync failure");
  a_status_set: assert property ((mon_fail && !o_sync_fail_msg) |=>
    st_reg[ST_FAIL]) else $error("Fail event lost");
endmodule
`default_nettype wire

// ===== hdl/ctsu_uart_rx.sv
`timescale 1ns/1ps
`default_nettype none
module ctsu_uart_rx #(
  parameter int P_DIV_W = 18
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_rx,
  input wire logic [P_DIV_W-1:0] i_div,
  output logic [7:0] o_data,
  output logic o_valid
);
  if (P_DIV_W < 4) begin : g_chk
    $error("Divider too narrow");
  end
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} ctsu_rx_state_t;
  ctsu_rx_state_t st_reg, st_next;
  logic [P_DIV_W-1:0] cnt_reg, cnt_next;
  logic [2:0] bit_reg, bit_next;
  logic [7:0] sh_reg, sh_next;
  logic vld_reg, vld_next;

  always_comb begin
    st_next = st_reg;
    cnt_next = (cnt_reg == '0) ? i_div - 1'b1 : cnt_reg - 1'b1;
    bit_next = bit_reg;
    sh_next = sh_reg;
    vld_next = 1'b0;
    case (st_reg)
      RX_IDLE: begin
        cnt_next = i_div >> 1;
        if (!i_rx) st_next = RX_START;
      end
      RX_START: if (cnt_reg == '0) begin
        bit_next = 3'h0;
        st_next = i_rx ? RX_IDLE : RX_DATA;
      end
      RX_DATA: if (cnt_reg == '0) begin
        sh_next = {i_rx, sh_reg[7:1]};
        bit_next = bit_reg + 3'h1;
        if (bit_reg == 3'h7) st_next = RX_STOP;
      end
      RX_STOP: if (cnt_reg == '0) begin
        vld_next = i_rx;
        st_next = RX_IDLE;
      end
      default: st_next = RX_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      st_reg <= RX_IDLE;
      cnt_reg <= '0;
      bit_reg <= 3'h0;
      sh_reg <= 8'h00;
      vld_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      bit_reg <= bit_next;
      sh_reg <= sh_next;
      vld_reg <= vld_next;
    end
  end
  assign o_data = sh_reg;
  assign o_valid = vld_reg;
endmodule
`default_nettype wire

// ===== verif/ctsu_sync_src.sv
`timescale 1ns/1ps
`default_nettype none
module ctsu_sync_src #(
  parameter int P_HALF = 2,
  parameter int P_BIT = 2170
) (
  input wire logic i_clk,
  input wire logic i_run,
  input wire logic i_sat_go,
  output logic o_mains,
  output logic o_sat_rx
);
  localparam logic [7:0] FRAME [3] = '{8'h8a, 8'h1e, 8'h00};
  int cnt;
  logic sat_line;
  initial begin
    o_mains = 1'b0;
    cnt = 0;
  end
  // Mains square wave; a lost reference freezes at its last level
  always @(posedge i_clk) begin
    if (i_run) begin
      cnt <= (cnt + 1 >= P_HALF) ? 0 : cnt + 1;
      if (cnt + 1 >= P_HALF) begin
        o_mains <= ~o_mains;
      end
    end
  end
  // One 8N1 frame of 10:30:00 per rising i_sat_go; P_BIT must match the baud code the bench writes
  initial begin
    sat_line = 1'b1;
    forever begin
      @(posedge i_sat_go);
      foreach (FRAME[b]) begin
        for (int k = 0; k < 10; k++) begin
          sat_line <= (k == 0) ? 1'b0 : (k == 9) ? 1'b1 : FRAME[b][k-1];
          repeat (P_BIT) @(posedge i_clk);
        end
      end
    end
  end
  assign o_sat_rx = sat_line;
endmodule
`default_nettype wire

// ===== verif/tb_ctsu_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_ctsu_top import ctsu_pkg::*;;
  typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e;} ctsu_tb_row_t;
  logic i_clk, i_reset, i_wr, i_rd, run, sat_go, i_mains, i_sat_rx, o_sync_fail_msg, o_irq;
  logic [7:0] i_addr, o_relay;
  logic [31:0] i_wdata, o_rdata, v;
  ctsu_disp_t o_disp;
  logic [11:0] o_year;
  logic [3:0] o_month;
  logic [15:0] o_day_count;
  int failures, samples_checked;
  // Reset values first, then writes with their expected readback
  ctsu_tb_row_t rows[23] = '{
    '{1'b0, A_CTRL, 32'h0, 32'h42}, '{1'b0, A_BAUD, 32'h0, 32'h2},
    '{1'b0, A_ADJ_SEC, 32'h0, 32'h0}, '{1'b0, A_ADJ_HOUR, 32'h0, 32'h0},
    '{1'b0, A_UTC, 32'h0, 32'h14}, '{1'b0, A_YEAR, 32'h0, 32'h7da},
    '{1'b0, A_MONTH, 32'h0, 32'h1}, '{1'b1, A_BAUD, 32'h3, 32'h3},
    '{1'b1, A_CTRL, 32'h52, 32'h52}, '{1'b1, A_ADJ_HOUR, 32'h18, 32'h18},
    '{1'b1, A_ADJ_HOUR, 32'h19, 32'h18}, '{1'b1, A_ADJ_HOUR, 32'h28, 32'h28},
    '{1'b1, A_UTC, 32'h1b, 32'h14}, '{1'b1, A_UTC, 32'h7, 32'h7},
    '{1'b1, A_UTC, 32'h28, 32'h28}, '{1'b1, A_UTC, 32'h40, 32'h40},
    '{1'b1, A_YEAR, 32'h833, 32'h833}, '{1'b1, A_YEAR, 32'h834, 32'h833},
    '{1'b1, A_MONTH, 32'h0, 32'h1}, '{1'b1, A_MONTH, 32'hc, 32'hc},
    '{1'b1, A_MONTH, 32'hd, 32'hc}, '{1'b1, A_CTRL, 32'h1d2, 32'h52},
    '{1'b1, 8'h30, 32'hff, 32'h0}};

  ctsu_top #(.P_CYC_PER_TENTH(10), .P_SYNC_TIMEOUT(200)) ctsu_top_inst (
    .i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_mains(i_mains), .i_sat_rx(i_sat_rx), .o_disp(o_disp),
    .o_day_count(o_day_count), .o_year(o_year), .o_month(o_month), .o_sync_fail_msg(o_sync_fail_msg),
    .o_relay(o_relay), .o_irq(o_irq));
  ctsu_sync_src ctsu_sync_src_inst (.i_clk(i_clk), .i_run(run), .i_sat_go(sat_go), .o_mains(i_mains),
    .o_sat_rx(i_sat_rx));

  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  task automatic rt(input logic [31:0] e);
    rd(A_TIME, v);
    check("time", v, e);
  endtask
  task automatic hrs(input logic [31:0] e);
    repeat (2) @(posedge i_clk);
    #1 check("hours", 32'(o_disp.hours), e);
  endtask
  task automatic wait_fail(input logic lvl);
    for (int n = 0; n < 400 && o_sync_fail_msg !== lvl; n++) @(posedge i_clk);
    #1 check("sync_fail", 32'(o_sync_fail_msg), 32'(lvl));
    // A wait that ran out ends the run at once
    if (o_sync_fail_msg !== lvl) end_of_test();
  endtask
  task automatic end_of_test;
    $display("Counts: %0d compared, %0d failed", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  initial begin
    #400000;
    failures++;
    end_of_test();
  end
  initial begin
    i_reset = 1'b1;
    {i_wr, i_rd, i_addr, i_wdata, sat_go} = '0;
    run = 1'b1;
    failures = 0;
    samples_checked = 0;
    repeat (5) @(posedge i_clk);
    i_reset <= 1'b0;
    foreach (rows[k]) begin
      if (rows[k].w) wr(rows[k].a, rows[k].d);
      rd(rows[k].a, v);
      check("register", v, rows[k].e);
    end
    check("year_out", 32'(o_year), 32'h833);
    check("month_out", 32'(o_month), 32'hc);
    wr(A_RELAY, 32'hff);
    @(posedge i_clk);
    #1 check("relay", 32'(o_relay), 32'hf);
    $display("Table and relay test done");
    wr(A_TIME, 32'd100);
    wr(A_TIME, 32'd86400);
    rt(32'd100);
    wr(A_TIME, 32'd86399);
    wr(A_ADJ_SEC, 32'hffce);
    rt(32'd86394);
    wr(A_TIME, 32'd0);
    wr(A_ADJ_SEC, 32'hfff6);
    rt(32'd86399);
    wr(A_CTRL, 32'h50);
    wr(A_TIME, 32'd100);
    wr(A_ADJ_SEC, 32'h64);
    rt(32'd100);
    wr(A_CTRL, 32'h60);
    wr(A_ADJ_SEC, 32'h64);
    rt(32'd110);
    $display("Adjust test done");
    wr(A_TIME, 32'd47100);
    wr(A_CTRL, 32'h61);
    hrs(32'd1);
    check("pm", 32'(o_disp.pm), 32'h1);
    check("minutes", 32'(o_disp.minutes), 32'd5);
    wr(A_CTRL, 32'h60);
    hrs(32'd13);
    wr(A_ADJ_HOUR, 32'h3f);
    hrs(32'd12);
    for (int f = 0; f < 7; f++) begin
      wr(A_CTRL, 32'h20 | (f << 6));
      rd(A_CTRL, v);
      check("fmt", 32'(o_disp.fmt), f);
      check("fmt_read", v, 32'h20 | (f << 6));
    end
    $display("Display test done");
    wr(A_CTRL, 32'h44);
    wr(A_TIME, 32'd0);
    repeat (2100) @(posedge i_clk);
    rt(32'd10);
    wr(A_CTRL, 32'h48);
    wr(A_TIME, 32'd0);
    repeat (2520) @(posedge i_clk);
    rt(32'd10);
    run <= 1'b0;
    wait_fail(1'b1);
    check("irq_masked", 32'(o_irq), 32'h0);
    rd(A_STATUS, v);
    check("status", v, 32'h1);
    wr(A_MASK, 32'h1);
    @(posedge i_clk);
    #1 check("irq_set", 32'(o_irq), 32'h1);
    wr(A_STATUS, 32'h1);
    @(posedge i_clk);
    #1 check("irq_clear", 32'(o_irq), 32'h0);
    run <= 1'b1;
    wait_fail(1'b0);
    $display("Sync test done");
    i_reset <= 1'b1;
    @(posedge i_clk);
    i_reset <= 1'b0;
    rd(A_CTRL, v);
    check("ctrl_reset", v, 32'h42);
    check("year_reset", 32'(o_year), 32'h7da);
    $display("Second reset test done");
    wr(A_TIME, 32'd86399);
    repeat (120) @(posedge i_clk);
    #1 check("days", 32'(o_day_count), 32'h1);
    wr(A_BAUD, 32'h7);
    wr(A_MASK, 32'h2);
    wr(A_CTRL, 32'h4e);
    sat_go <= 1'b1;
    for (int n = 0; n < 70000 && o_irq !== 1'b1; n++) @(posedge i_clk);
    #1 check("frame_irq", 32'(o_irq), 32'h1);
    if (o_irq !== 1'b1) end_of_test();
    rt(32'd73800);
    rd(A_STATUS, v);
    check("status_all", v, 32'h7);
    $display("Satellite test done");
    end_of_test();
  end
endmodule
`default_nettype wire
